// ===== include/dic_pkg.sv
// Overview of operation
// - Polarity picks energized reads 1 or 0
// - Normally open: above activation threshold activates
// - Normally closed: above activation threshold deactivates
// - Normally open: below release threshold deactivates
// - Normally closed: below release threshold activates
// - Activation delay in ms before 0-to-1
// - Drop-off delay in ms before 1-to-0
// - AC mode adds 30 ms drop-off delay
// - AC mode release is 10 % of activation
// - 32-bit counter counts 0-to-1 changes
// - Clear command zeroes channel counter
// - Thresholds held separately per channel
// - Present voltage readable in millivolts
// - All channels evaluated every 5 ms scan
//
// Purpose: Constants and types of the digital input conditioner
// Assumes: Eight channels, voltages arrive in millivolts
// Notes: Thresholds in 0.1 V units, delays in milliseconds
package dic_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int DIC_NCH = 8;
  localparam int DIC_CHW = 3;
  localparam int DIC_VW = 19;
  localparam int DIC_TW = 11;
  localparam int DIC_DW = 21;
  localparam int DIC_TMW = 22;
  localparam int DIC_CW = 32;
  localparam int DIC_AW = 8;
  localparam int DIC_RW = 4;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int DIC_CLK_HZ = 40_000_000;
  localparam int DIC_MS_PER_S = 1000;
  localparam int DIC_MS_CYC = DIC_CLK_HZ / DIC_MS_PER_S;
  localparam int DIC_SCAN_MS = 5;
  localparam int DIC_AC_DROP_MS = 30;

  // ----------------------------------------
  // Scaling and reset values
  // ----------------------------------------
  localparam int DIC_MV_PER_DV = 100;
  localparam int DIC_AC_PCT = 10;
  localparam int DIC_PCT_FULL = 100;
  localparam logic [DIC_TW-1:0] DIC_ACT_DEF = 11'h370;
  localparam logic [DIC_TW-1:0] DIC_REL_DEF = 11'h258;
  localparam logic [DIC_DW-1:0] DIC_DLY_DEF = 21'h00_0000;

  // ----------------------------------------
  // Register map: addr = {channel, index}
  // ----------------------------------------
  localparam logic [DIC_RW-1:0] DIC_REG_CTRL = 4'h0;
  localparam logic [DIC_RW-1:0] DIC_REG_ACT = 4'h1;
  localparam logic [DIC_RW-1:0] DIC_REG_REL = 4'h2;
  localparam logic [DIC_RW-1:0] DIC_REG_ADLY = 4'h3;
  localparam logic [DIC_RW-1:0] DIC_REG_DDLY = 4'h4;
  localparam logic [DIC_RW-1:0] DIC_REG_CNT = 4'h5;
  localparam logic [DIC_RW-1:0] DIC_REG_VOLT = 4'h6;
  localparam logic [DIC_RW-1:0] DIC_REG_STAT = 4'h7;
  localparam int DIC_CTRL_NC_BIT = 0;
  localparam int DIC_CTRL_AC_BIT = 1;
  localparam int DIC_STAT_OUT_BIT = 0;
  localparam int DIC_STAT_RAW_BIT = 1;

  // Per-channel settings
  typedef struct packed {
    logic nc;
    logic alternating_current_mode;
    logic [DIC_TW-1:0] act_thr;
    logic [DIC_TW-1:0] rel_thr;
    logic [DIC_DW-1:0] act_dly;
    logic [DIC_DW-1:0] drop_dly;
  } dic_cfg_t;

  localparam dic_cfg_t DIC_CFG_DEF = '{
    nc: 1'b0,
    alternating_current_mode: 1'b0,
    act_thr: DIC_ACT_DEF,
    rel_thr: DIC_REL_DEF,
    act_dly: DIC_DLY_DEF,
    drop_dly: DIC_DLY_DEF
  };

endpackage

// ===== rtl/dic_input_conditioner.sv
// Purpose: Threshold, polarity, delay and counting for digital inputs
// Assumes: Voltages in mV from logic on the same clock
// Notes: Registers over a plain strobe port, read data one cycle later
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module dic_input_conditioner #(
  parameter int MS_CYC = dic_pkg::DIC_MS_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [dic_pkg::DIC_NCH-1:0][dic_pkg::DIC_VW-1:0] chan_mv,
  input wire logic [dic_pkg::DIC_AW-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic [dic_pkg::DIC_NCH-1:0] input_channel_n,
  output logic scan_tick
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // 0.1 V units to millivolts
  function automatic logic [dic_pkg::DIC_VW-1:0] to_mv(
    input logic [dic_pkg::DIC_TW-1:0] dv
  );
    logic [31:0] p;
    p = 32'(dv) * 32'(dic_pkg::DIC_MV_PER_DV);
    return p[dic_pkg::DIC_VW-1:0];
  endfunction

  // Effective release level in mV
  function automatic logic [dic_pkg::DIC_VW-1:0] rel_mv(
    input dic_pkg::dic_cfg_t c
  );
    logic [31:0] p;
    p = 32'(to_mv(c.act_thr)) * 32'(dic_pkg::DIC_AC_PCT)
      / 32'(dic_pkg::DIC_PCT_FULL);
    if (c.alternating_current_mode)
    begin
      return p[dic_pkg::DIC_VW-1:0];
    end
    return to_mv(c.rel_thr);
  endfunction

  // Hysteresis on the energized level
  function automatic logic energized(
    input logic [dic_pkg::DIC_VW-1:0] v,
    input dic_pkg::dic_cfg_t c,
    input logic prev
  );
    if (v > to_mv(c.act_thr))
    begin
      return 1'b1;
    end
    if (v < rel_mv(c))
    begin
      return 1'b0;
    end
    return prev;
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  dic_pkg::dic_cfg_t cfg_ff [dic_pkg::DIC_NCH];
  logic [dic_pkg::DIC_NCH-1:0] energ_ff;
  logic [dic_pkg::DIC_NCH-1:0] raw_ff;
  logic [dic_pkg::DIC_NCH-1:0] out_ff;
  logic [dic_pkg::DIC_TMW-1:0] tmr_ff [dic_pkg::DIC_NCH];
  logic [dic_pkg::DIC_CW-1:0] rising_transition_count_ff [dic_pkg::DIC_NCH];
  logic [dic_pkg::DIC_VW-1:0] present_channel_voltage_ff [dic_pkg::DIC_NCH];
  logic [31:0] ms_cnt_ff;
  logic [2:0] scan_cnt_ff;
  logic ms_tick_ff;
  logic scan_tick_ff;
  logic [31:0] rdata_ff;

  logic [dic_pkg::DIC_NCH-1:0] nxt_energ;
  logic [dic_pkg::DIC_NCH-1:0] nxt_raw;
  logic [dic_pkg::DIC_NCH-1:0] commit;
  logic [dic_pkg::DIC_NCH-1:0] transition_count_clear;
  logic [dic_pkg::DIC_CHW-1:0] sel_ch;
  logic [dic_pkg::DIC_RW-1:0] sel_reg;
  logic sel_ok;

  assign sel_ch = addr[dic_pkg::DIC_RW +: dic_pkg::DIC_CHW];
  assign sel_reg = addr[dic_pkg::DIC_RW-1:0];
  assign sel_ok = addr[dic_pkg::DIC_AW-1] == 1'b0;

  // ----------------------------------------
  // Millisecond and scan dividers
  // ----------------------------------------
  // One-cycle enable every millisecond
  always_ff @(posedge clk)
  begin
    if (rst || ms_cnt_ff == 32'(MS_CYC - 1))
    begin
      ms_cnt_ff <= 32'h0000_0000;
    end
    else
    begin
      ms_cnt_ff <= ms_cnt_ff + 32'h0000_0001;
    end
    ms_tick_ff <= !rst && ms_cnt_ff == 32'(MS_CYC - 1);
  end

  // One-cycle scan enable every fifth millisecond
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      scan_cnt_ff <= 3'h0;
      scan_tick_ff <= 1'b0;
    end
    else
    begin
      scan_tick_ff <= 1'b0;
      if (ms_tick_ff)
      begin
        if (scan_cnt_ff == 3'(dic_pkg::DIC_SCAN_MS - 1))
        begin
          scan_cnt_ff <= 3'h0;
          scan_tick_ff <= 1'b1;
        end
        else
        begin
          scan_cnt_ff <= scan_cnt_ff + 3'h1;
        end
      end
    end
  end

  assign scan_tick = scan_tick_ff;

  // ----------------------------------------
  // Channel evaluation
  // ----------------------------------------
  // Raw level, polarity and delay check per channel
  always_comb
  begin
    for (int i = 0; i < dic_pkg::DIC_NCH; i++)
    begin
      logic [dic_pkg::DIC_TMW-1:0] need;
      logic [dic_pkg::DIC_TMW-1:0] elapsed;
      need = '0;
      elapsed = '0;
      nxt_energ[i] = energized(chan_mv[i], cfg_ff[i], energ_ff[i]);
      nxt_raw[i] = nxt_energ[i] ^ cfg_ff[i].nc;
      if (nxt_raw[i])
      begin
        need = dic_pkg::DIC_TMW'(cfg_ff[i].act_dly);
      end
      else
      begin
        need = dic_pkg::DIC_TMW'(cfg_ff[i].drop_dly);
        if (cfg_ff[i].alternating_current_mode)
        begin
          need = need + dic_pkg::DIC_TMW'(dic_pkg::DIC_AC_DROP_MS);
        end
      end
      elapsed = (raw_ff[i] == nxt_raw[i]) ? tmr_ff[i] : '0;
      commit[i] = scan_tick_ff && nxt_raw[i] != out_ff[i]
        && elapsed >= need;
    end
  end

  // Raw level and voltage sample taken once per scan
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < dic_pkg::DIC_NCH; i++)
    begin
      if (rst)
      begin
        energ_ff[i] <= 1'b0;
        raw_ff[i] <= 1'b0;
        present_channel_voltage_ff[i] <= '0;
      end
      else if (scan_tick_ff)
      begin
        energ_ff[i] <= nxt_energ[i];
        raw_ff[i] <= nxt_raw[i];
        present_channel_voltage_ff[i] <= chan_mv[i];
      end
    end
  end

  // Time since raw level left the reported state
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < dic_pkg::DIC_NCH; i++)
    begin
      if (rst || raw_ff[i] == out_ff[i] || commit[i])
      begin
        tmr_ff[i] <= '0;
      end
      else if (scan_tick_ff && raw_ff[i] != nxt_raw[i])
      begin
        tmr_ff[i] <= '0;
      end
      else if (ms_tick_ff && tmr_ff[i] != '1)
      begin
        tmr_ff[i] <= tmr_ff[i]
          + dic_pkg::DIC_TMW'(1'b1);
      end
    end
  end

  // Reported state
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < dic_pkg::DIC_NCH; i++)
    begin
      if (rst)
      begin
        out_ff[i] <= 1'b0;
      end
      else if (commit[i])
      begin
        out_ff[i] <= nxt_raw[i];
      end
    end
  end

  assign input_channel_n = out_ff;

  // Rising transition counters, clear with a same-cycle increment loads one
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < dic_pkg::DIC_NCH; i++)
    begin
      if (rst)
      begin
        rising_transition_count_ff[i] <= '0;
      end
      else if (commit[i] && nxt_raw[i])
      begin
        if (transition_count_clear[i])
        begin
          rising_transition_count_ff[i] <= 32'h0000_0001;
        end
        else
        begin
          rising_transition_count_ff[i] <= rising_transition_count_ff[i]
            + 32'h0000_0001;
        end
      end
      else if (transition_count_clear[i])
      begin
        rising_transition_count_ff[i] <= '0;
      end
    end
  end

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  // Clear strobe from a write to the counter register
  always_comb
  begin
    transition_count_clear = '0;
    if (wr && sel_ok && sel_reg == dic_pkg::DIC_REG_CNT)
    begin
      transition_count_clear[sel_ch] = 1'b1;
    end
  end

  // Per-channel settings writes
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < dic_pkg::DIC_NCH; i++)
      begin
        cfg_ff[i] <= dic_pkg::DIC_CFG_DEF;
      end
    end
    else if (wr && sel_ok)
    begin
      unique case (sel_reg)
        dic_pkg::DIC_REG_CTRL:
        begin
          cfg_ff[sel_ch].nc <= wdata[dic_pkg::DIC_CTRL_NC_BIT];
          cfg_ff[sel_ch].alternating_current_mode <=
            wdata[dic_pkg::DIC_CTRL_AC_BIT];
        end
        dic_pkg::DIC_REG_ACT:
        begin
          cfg_ff[sel_ch].act_thr <= wdata[dic_pkg::DIC_TW-1:0];
        end
        dic_pkg::DIC_REG_REL:
        begin
          cfg_ff[sel_ch].rel_thr <= wdata[dic_pkg::DIC_TW-1:0];
        end
        dic_pkg::DIC_REG_ADLY:
        begin
          cfg_ff[sel_ch].act_dly <= wdata[dic_pkg::DIC_DW-1:0];
        end
        dic_pkg::DIC_REG_DDLY:
        begin
          cfg_ff[sel_ch].drop_dly <= wdata[dic_pkg::DIC_DW-1:0];
        end
        default:
        begin
        end
      endcase
    end
  end

  // Read data, valid the cycle after the strobe only
  always_ff @(posedge clk)
  begin
    rdata_ff <= 32'h0000_0000;
    if (!rst && rd && sel_ok)
    begin
      unique case (sel_reg)
        dic_pkg::DIC_REG_CTRL:
        begin
          rdata_ff[dic_pkg::DIC_CTRL_NC_BIT] <= cfg_ff[sel_ch].nc;
          rdata_ff[dic_pkg::DIC_CTRL_AC_BIT] <=
            cfg_ff[sel_ch].alternating_current_mode;
        end
        dic_pkg::DIC_REG_ACT:
        begin
          rdata_ff <= 32'(cfg_ff[sel_ch].act_thr);
        end
        dic_pkg::DIC_REG_REL:
        begin
          rdata_ff <= 32'(cfg_ff[sel_ch].rel_thr);
        end
        dic_pkg::DIC_REG_ADLY:
        begin
          rdata_ff <= 32'(cfg_ff[sel_ch].act_dly);
        end
        dic_pkg::DIC_REG_DDLY:
        begin
          rdata_ff <= 32'(cfg_ff[sel_ch].drop_dly);
        end
        dic_pkg::DIC_REG_CNT:
        begin
          rdata_ff <= rising_transition_count_ff[sel_ch];
        end
        dic_pkg::DIC_REG_VOLT:
        begin
          rdata_ff <= 32'(present_channel_voltage_ff[sel_ch]);
        end
        dic_pkg::DIC_REG_STAT:
        begin
          rdata_ff[dic_pkg::DIC_STAT_OUT_BIT] <= out_ff[sel_ch];
          rdata_ff[dic_pkg::DIC_STAT_RAW_BIT] <= raw_ff[sel_ch];
        end
        default:
        begin
          rdata_ff <= 32'h0000_0000; // Unmapped reads zero
        end
      endcase
    end
  end

  assign rdata = rdata_ff;

endmodule

// ===== tb/dic_checker.sv
// Purpose: Port assertions for the input conditioner
// Assumes: Sees only the top module ports
// Notes: Scan period is five ms ticks of MS_CYC clocks
`timescale 1ns/1ps
module dic_checker #(
  parameter int MS_CYC = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [dic_pkg::DIC_NCH-1:0][dic_pkg::DIC_VW-1:0] chan_mv,
  input wire logic [dic_pkg::DIC_AW-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic [dic_pkg::DIC_NCH-1:0] input_channel_n,
  input wire logic scan_tick
);
  localparam int SCAN = dic_pkg::DIC_SCAN_MS * MS_CYC;
  logic sel_out;

  // State of the addressed channel
  assign sel_out = input_channel_n[addr[6:4]];

  logic [dic_pkg::DIC_NCH-1:0][dic_pkg::DIC_VW-1:0] volt_seen;
  logic [dic_pkg::DIC_VW-1:0] sel_volt;

  // Voltages as sampled at each scan
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      volt_seen <= '0;
    end
    else if (scan_tick)
    begin
      volt_seen <= chan_mv;
    end
  end

  // Sampled voltage of the addressed channel
  assign sel_volt = volt_seen[addr[6:4]];

  // ---
  // Assertions
  // ---
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  property p_rd_idle;
    !$past(rd) |-> rdata == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not idle");

  property p_unmap;
    rd && addr[7] |=> rdata == 32'h0000_0000;
  endproperty
  a_unmap: assert property (p_unmap)
    else $error("unmapped read not zero");

  property p_out_scan;
    $changed(input_channel_n) |-> $past(scan_tick);
  endproperty
  a_out_scan: assert property (p_out_scan)
    else $error("state moved off scan");

  property p_scan_gap;
    scan_tick |=> (!scan_tick)[*8];
  endproperty
  a_scan_gap: assert property (p_scan_gap)
    else $error("scan ticks too close");

  property p_scan_per;
    scan_tick |-> ##SCAN scan_tick;
  endproperty
  a_scan_per: assert property (p_scan_per)
    else $error("scan period wrong");

  property p_stat;
    rd && addr[3:0] == 4'h7 && !addr[7] |=>
      rdata[0] == $past(sel_out) && rdata[31:2] == 30'h0000_0000;
  endproperty
  a_stat: assert property (p_stat)
    else $error("status read wrong");

  property p_ctrl;
    wr && addr[3:0] == 4'h0 && !addr[7] ##2 rd && addr == $past(addr, 2)
      |=> rdata == ($past(wdata, 3) & 32'h0000_0003);
  endproperty
  a_ctrl: assert property (p_ctrl)
    else $error("control readback wrong");

  property p_act;
    wr && addr[3:0] == 4'h1 && !addr[7] ##2 rd && addr == $past(addr, 2)
      |=> rdata == ($past(wdata, 3) & 32'h0000_07FF);
  endproperty
  a_act: assert property (p_act)
    else $error("threshold readback wrong");

  property p_volt;
    rd && addr[3:0] == 4'h6 && !addr[7] |=>
      rdata == 32'($past(sel_volt));
  endproperty
  a_volt: assert property (p_volt)
    else $error("voltage read wrong");
endmodule

bind dic_input_conditioner dic_checker #(.MS_CYC(MS_CYC)) chk_u (
  .clk(clk), .rst(rst), .chan_mv(chan_mv), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .input_channel_n(input_channel_n),
  .scan_tick(scan_tick)
);

// ===== tb/dic_input_conditioner_bench.sv
// Purpose: Self-checking bench of the input conditioner
// Assumes: MS_CYC of 4, so one ms is four clocks
// Notes: Scenarios run in order after one reset
`timescale 1ns/1ps
module dic_input_conditioner_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [dic_pkg::DIC_NCH-1:0][dic_pkg::DIC_VW-1:0] chan_mv = '0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [7:0] input_channel_n;
  logic scan_tick;
  int error_cnt = 0;
  int checked = 0;

  // Clock of 25 ns
  always #12.5 clk = ~clk;

  dic_input_conditioner #(.MS_CYC(4)) dut_u (
    .clk(clk), .rst(rst), .chan_mv(chan_mv), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .input_channel_n(input_channel_n),
    .scan_tick(scan_tick)
  );

  // ---
  // Shared tasks
  // ---
  task cmp(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task rd_reg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    cmp(rdata, e);
  endtask

  task setv(input int ch, input logic [18:0] v);
    @(posedge clk);
    chan_mv[ch] <= v;
  endtask

  // Wait for n scan ticks and their update
  task scans(input int n);
    repeat (n)
    begin
      @(negedge clk);
      while (scan_tick !== 1'b1)
        @(negedge clk);
      @(negedge clk);
    end
  endtask

  task chk(input int ch, input logic e);
    cmp({31'h0000_0000, input_channel_n[ch]}, {31'h0000_0000, e});
  endtask

  // ---
  // Scenarios
  // ---
  task t_defaults;
    rd_reg(8'h00, 32'h0000_0000);
    rd_reg(8'h01, 32'h0000_0370);
    rd_reg(8'h02, 32'h0000_0258);
    rd_reg(8'h03, 32'h0000_0000);
    rd_reg(8'h04, 32'h0000_0000);
    rd_reg(8'h05, 32'h0000_0000);
    rd_reg(8'h80, 32'h0000_0000);
  endtask

  task t_thresh;
    setv(0, 19'h1_57C0);
    scans(2);
    chk(0, 1'b0);
    setv(0, 19'h1_57C1);
    scans(1);
    chk(0, 1'b1);
    setv(0, 19'h1_1170);
    scans(2);
    chk(0, 1'b1);
    setv(0, 19'h0_EA60);
    scans(2);
    chk(0, 1'b1);
    setv(0, 19'h0_EA5F);
    scans(1);
    chk(0, 1'b0);
    rd_reg(8'h06, 32'h0000_EA5F);
    rd_reg(8'h05, 32'h0000_0001);
  endtask

  task t_nc;
    wr_reg(8'h10, 32'h0000_0001);
    rd_reg(8'h10, 32'h0000_0001);
    scans(1);
    chk(1, 1'b1);
    setv(1, 19'h1_5F90);
    scans(1);
    chk(1, 1'b0);
    chk(0, 1'b0);
  endtask

  task t_chan;
    wr_reg(8'h21, 32'h0000_01F4);
    rd_reg(8'h21, 32'h0000_01F4);
    setv(2, 19'h0_EA60);
    setv(3, 19'h0_EA60);
    scans(1);
    chk(2, 1'b1);
    chk(3, 1'b0);
    wr_reg(8'h32, 32'h0000_012C);
    rd_reg(8'h32, 32'h0000_012C);
    setv(3, 19'h1_5F90);
    scans(1);
    chk(3, 1'b1);
    setv(3, 19'h0_9C40);
    scans(1);
    chk(3, 1'b1);
    setv(3, 19'h0_752F);
    scans(1);
    chk(3, 1'b0);
  endtask

  task t_delay;
    wr_reg(8'h43, 32'h0000_000A);
    wr_reg(8'h44, 32'h0000_0014);
    rd_reg(8'h43, 32'h0000_000A);
    rd_reg(8'h44, 32'h0000_0014);
    setv(4, 19'h1_5F90);
    scans(2);
    chk(4, 1'b0);
    rd_reg(8'h47, 32'h0000_0002);
    scans(1);
    chk(4, 1'b1);
    setv(4, 19'h0_0000);
    scans(4);
    chk(4, 1'b1);
    scans(1);
    chk(4, 1'b0);
  endtask

  task t_ac;
    wr_reg(8'h50, 32'h0000_0002);
    setv(5, 19'h1_5F90);
    scans(1);
    chk(5, 1'b1);
    setv(5, 19'h0_C350);
    scans(4);
    chk(5, 1'b1);
    setv(5, 19'h0_1F40);
    scans(6);
    chk(5, 1'b1);
    scans(1);
    chk(5, 1'b0);
  endtask

  task t_count;
    setv(0, 19'h1_5F90);
    scans(1);
    rd_reg(8'h05, 32'h0000_0002);
    rd_reg(8'h07, 32'h0000_0003);
    wr_reg(8'h05, 32'h0000_0000);
    rd_reg(8'h05, 32'h0000_0000);
    rd_reg(8'h15, 32'h0000_0001);
  endtask

  // Verdict and end of run
  task summarize;
    if (error_cnt == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_defaults();
    t_thresh();
    t_nc();
    t_chan();
    t_delay();
    t_ac();
    t_count();
    summarize();
  end

  // Watchdog against a hang
  initial
  begin
    #200_000;
    error_cnt++;
    summarize();
  end
endmodule
